// File: serial_flash_cmd.sv
// Serial flash opcode decoder and single/dual array read path
// Contract
// R1 - Accept array reads 1Bh, 0Bh, 03h; host limits clock per opcode.
// R2 - 1Bh takes two dummy bytes after address; output starts after them.
// R3 - 0Bh takes one dummy byte after address; output starts after it.
// R4 - 03h has no dummy; data starts on cycle after last address bit.
// R5 - Host asserts select, sends read opcode, then three address bytes.
// R6 - Read steps address counter, streams bytes MSB first without gaps.
// R7 - After top array address, continue at zero with no wait.
// R8 - Select deasserted anywhere ends read and releases outputs.
// R9 - Host uses fastest read above standard limit only with enhanced protocol.
// R10 - Decode block erases 20h/52h/D8h with address, chip erases 60h/C7h.
// R11 - Decode page program 02h: address then 1 to 256 data bytes.
// R12 - Decode dual page program A2h: address then up to 256 bytes.
// R13 - Decode 36h/39h with address only, 3Ch with address and read data.
// R14 - Decode 33h and 34h: address then exactly one data byte.
// R15 - Decode 35h: address, no dummy, then read data.
// R16 - Decode 9Bh: address then one or more data bytes.
// R17 - Decode 77h: address, two dummy bytes, then read data.
// R18 - Decode 05h read without address; 01h takes exactly one byte.
// R19 - Decode 31h: no address, exactly one data byte.
// R20 - Decode 9Fh: no address, one to four read bytes.
// R21 - Decode B9h, ABh opcode only; F0h followed by one byte.
// R22 - Decode 06h, 04h, B0h, D0h as opcode-only commands.
// R23 - Count bits from select; load opcode only after eight bits.
// R24 - Sample on rising serial clock, drive on falling; either idle level.
// R25 - Unsupported opcode: ignore input until select toggles.
// R26 - Ignore two top address bits; array address is 22 bits.
// R27 - 3Bh drives two bits per clock, MSB on normal output.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd
    import serial_flash_pkg::*;
#(
    parameter int ADDR_W = 22
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic dual_input_line_i,
    output logic so_o,
    output logic so_oe_o,
    output logic dual_data_line_o,
    output logic dual_data_line_oe_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [7:0] mem_data_i,
    output logic rd_byte_o,
    output logic cmd_start_o,
    output logic [7:0] opcode_o,
    output logic [ADDR_W-1:0] cmd_addr_o,
    output logic wr_valid_o,
    output logic [7:0] wr_data_o,
    output logic cmd_end_o,
    output logic cmd_aligned_o
);
    initial begin
        if (ADDR_W < 1 || ADDR_W > ADDR_BYTES * BYTE_W) begin
            $error("ADDR_W must lie within the three address bytes");
        end
    end

    function automatic cmd_info_t decode_cmd(input logic [7:0] op);
        cmd_info_t d;
        d = '0;
        case (op)
            OP_READ_MAX, OP_OTP_RD: // R1 R2 R17
                d = '{1'b1, THREE_BYTES, TWO_BYTES, DIR_OUT, 1'b0, 1'b0};
            OP_READ_FAST: // R1 R3
                d = '{1'b1, THREE_BYTES, ONE_BYTE, DIR_OUT, 1'b0, 1'b0};
            OP_READ_SLOW, OP_PROT_RD, OP_LOCK_RD: // R1 R4 R13 R15
                d = '{1'b1, THREE_BYTES, NO_BYTES, DIR_OUT, 1'b0, 1'b0};
            OP_READ_DUAL: // R27
                d = '{1'b1, THREE_BYTES, ONE_BYTE, DIR_OUT, 1'b1, 1'b0};
            OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_PROTECT,
            OP_UNPROTECT: // R10 R13
                d = '{1'b1, THREE_BYTES, NO_BYTES, DIR_NONE, 1'b0, 1'b0};
            OP_CHIP_ERASE, OP_CHIP_ERASE_ALT, OP_SUSPEND, OP_RESUME,
            OP_WR_EN, OP_WR_DIS, OP_SLEEP, OP_WAKE: // R10 R21 R22
                d = '{1'b1, NO_BYTES, NO_BYTES, DIR_NONE, 1'b0, 1'b0};
            OP_PROG, OP_OTP_PROG: // R11 R16
                d = '{1'b1, THREE_BYTES, NO_BYTES, DIR_IN, 1'b0, 1'b0};
            OP_PROG_DUAL: // R12
                d = '{1'b1, THREE_BYTES, NO_BYTES, DIR_IN, 1'b1, 1'b0};
            OP_LOCK, OP_LOCK_FREEZE: // R14
                d = '{1'b1, THREE_BYTES, NO_BYTES, DIR_IN, 1'b0, 1'b1};
            OP_STAT_RD, OP_ID_RD: // R18 R20
                d = '{1'b1, NO_BYTES, NO_BYTES, DIR_OUT, 1'b0, 1'b0};
            OP_STAT_WR1, OP_STAT_WR2, OP_SOFT_RESET: // R18 R19 R21
                d = '{1'b1, NO_BYTES, NO_BYTES, DIR_IN, 1'b0, 1'b1};
            default:
                d = '0; // R25
        endcase
        return d;
    endfunction

    // Pins come from the host's domain: two flops before any use
    logic [1:0] cs_m_q, sck_m_q, si_m_q, soi_m_q;
    logic cs_s_q, cs_d_q, sck_s_q, sck_d_q, si_s_q, soi_s_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_m_q <= 2'b11;
            sck_m_q <= 2'b00;
            si_m_q <= 2'b00;
            soi_m_q <= 2'b00;
            cs_d_q <= 1'b1;
            sck_d_q <= 1'b0;
        end else begin
            cs_m_q <= {cs_m_q[0], cs_n_i};
            sck_m_q <= {sck_m_q[0], sck_i};
            si_m_q <= {si_m_q[0], si_i};
            soi_m_q <= {soi_m_q[0], dual_input_line_i};
            cs_d_q <= cs_s_q;
            sck_d_q <= sck_s_q;
        end
    end
    assign cs_s_q = cs_m_q[1];
    assign sck_s_q = sck_m_q[1];
    assign si_s_q = si_m_q[1];
    assign soi_s_q = soi_m_q[1];

    logic rise, fall;
    // Edge detection works for either clock idle level
    assign rise = !cs_s_q && sck_s_q && !sck_d_q; // R24
    assign fall = !cs_s_q && !sck_s_q && sck_d_q; // R24

    state_t state_q;
    cmd_info_t info_q, info_now;
    logic [2:0] bit_q, obit_q, step_in, step_out;
    logic [1:0] byte_q;
    logic [7:0] in_sr_q, in_byte, out_sr_q, opcode_q;
    logic [23:0] addr_sr_q;
    logic [ADDR_W-1:0] rd_addr_q;
    logic dual_in, byte_done, hdr_done, load, active_q;
    logic so_q, so_oe_q, dual_q, dual_oe_q;

    assign dual_in = state_q == ST_DATA && info_q.dual && info_q.dir == DIR_IN;
    assign step_in = dual_in ? STEP_DUAL : STEP_SINGLE;
    assign step_out = info_q.dual ? STEP_DUAL : STEP_SINGLE;
    assign in_byte = dual_in ? {in_sr_q[5:0], soi_s_q, si_s_q}
                             : {in_sr_q[6:0], si_s_q};
    assign byte_done = bit_q == BIT_LAST
                       || (dual_in && bit_q == BIT_LAST_DUAL);
    assign info_now = decode_cmd(in_byte);
    assign hdr_done = rise && byte_done && (
        (state_q == ST_OPC && info_now.known
            && info_now.addr_bytes == NO_BYTES)
        || (state_q == ST_ADDR && byte_q == info_q.addr_bytes - 2'd1
            && info_q.dummy_bytes == NO_BYTES)
        || (state_q == ST_DUMMY && byte_q == info_q.dummy_bytes - 2'd1));

    // Command sequencing; select high restarts state and bit/byte counts, opcode and address are kept
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_OPC;
            bit_q <= BIT_FIRST;
            byte_q <= NO_BYTES;
            in_sr_q <= 8'h00;
            opcode_q <= 8'h00;
            info_q <= '0;
            addr_sr_q <= 24'h000000;
        end else if (cs_s_q) begin
            state_q <= ST_OPC; // R25
            bit_q <= BIT_FIRST; // R23
            byte_q <= NO_BYTES;
        end else if (rise) begin
            bit_q <= bit_q + step_in; // R23
            in_sr_q <= in_byte;
            unique case (state_q)
                ST_OPC: begin
                    if (byte_done) begin
                        opcode_q <= in_byte; // R23
                        info_q <= info_now;
                        if (!info_now.known) begin
                            state_q <= ST_IGNORE; // R25
                        end else if (info_now.addr_bytes != NO_BYTES) begin
                            state_q <= ST_ADDR;
                        end else if (info_now.dir != DIR_NONE) begin
                            state_q <= ST_DATA;
                        end else begin
                            state_q <= ST_IGNORE; // R22
                        end
                    end
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        addr_sr_q <= {addr_sr_q[15:0], in_byte};
                        byte_q <= byte_q + 2'd1;
                        if (byte_q == info_q.addr_bytes - 2'd1) begin
                            byte_q <= NO_BYTES;
                            if (info_q.dummy_bytes != NO_BYTES) begin
                                state_q <= ST_DUMMY; // R2 R3 R17
                            end else if (info_q.dir != DIR_NONE) begin
                                state_q <= ST_DATA; // R4
                            end else begin
                                state_q <= ST_IGNORE; // R10 R13
                            end
                        end
                    end
                end
                ST_DUMMY: begin
                    // Dummy contents are never looked at
                    if (byte_done) begin
                        byte_q <= byte_q + 2'd1;
                        if (byte_q == info_q.dummy_bytes - 2'd1) begin
                            state_q <= ST_DATA; // R2 R3 R27
                        end
                    end
                end
                ST_DATA: begin
                    if (byte_done && info_q.dir == DIR_IN
                        && info_q.one_byte) begin
                        state_q <= ST_IGNORE; // R14 R18 R19 R21
                    end
                end
                ST_IGNORE: begin
                end
                default: state_q <= ST_IGNORE;
            endcase
        end
    end

    // Read pointer; only the low array bits are kept so it wraps freely
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_addr_q <= '0;
        end else if (hdr_done) begin
            if (state_q == ST_ADDR) begin
                rd_addr_q <= ADDR_W'({addr_sr_q[15:0], in_byte}); // R26
            end else if (state_q == ST_DUMMY) begin
                rd_addr_q <= addr_sr_q[ADDR_W-1:0]; // R26
            end else begin
                rd_addr_q <= '0;
            end
        end else if (load) begin
            rd_addr_q <= rd_addr_q + ADDR_W'(1); // R6 R7
        end
    end

    // Output shifter on the falling edge, a new byte every 8 or 4 clocks
    assign load = fall && state_q == ST_DATA && info_q.dir == DIR_OUT
                  && obit_q == BIT_FIRST;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
            dual_q <= 1'b0;
            dual_oe_q <= 1'b0;
            out_sr_q <= 8'h00;
            obit_q <= BIT_FIRST;
        end else if (cs_s_q) begin
            so_oe_q <= 1'b0; // R8
            dual_oe_q <= 1'b0; // R8
            obit_q <= BIT_FIRST;
        end else if (fall && state_q == ST_DATA && info_q.dir == DIR_OUT) begin
            so_oe_q <= 1'b1; // R24
            dual_oe_q <= info_q.dual; // R27
            obit_q <= obit_q + step_out;
            if (obit_q == BIT_FIRST) begin
                out_sr_q <= mem_data_i;
                so_q <= mem_data_i[7]; // R6
                dual_q <= mem_data_i[6]; // R27
            end else begin
                so_q <= out_sr_q[3'd7 - obit_q]; // R6
                dual_q <= out_sr_q[3'd6 - obit_q]; // R27
            end
        end
    end

    // Strobes towards the array and command execution logic
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_start_o <= 1'b0;
            wr_valid_o <= 1'b0;
            wr_data_o <= 8'h00;
            rd_byte_o <= 1'b0;
            cmd_end_o <= 1'b0;
            cmd_aligned_o <= 1'b0;
            active_q <= 1'b0;
        end else begin
            cmd_start_o <= hdr_done;
            rd_byte_o <= load;
            wr_valid_o <= rise && byte_done && dual_in == info_q.dual
                          && state_q == ST_DATA && info_q.dir == DIR_IN;
            if (rise && byte_done && state_q == ST_DATA) begin
                wr_data_o <= in_byte; // R11 R12
            end
            cmd_end_o <= cs_s_q && !cs_d_q && active_q;
            if (cs_s_q && !cs_d_q) begin
                cmd_aligned_o <= bit_q == BIT_FIRST;
                active_q <= 1'b0;
            end else if (hdr_done) begin
                active_q <= 1'b1;
            end
        end
    end

    assign so_o = so_q;
    assign so_oe_o = so_oe_q;
    assign dual_data_line_o = dual_q;
    assign dual_data_line_oe_o = dual_oe_q;
    assign mem_addr_o = rd_addr_q;
    assign opcode_o = opcode_q;
    assign cmd_addr_o = addr_sr_q[ADDR_W-1:0]; // R26

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    oe_release_a: assert property // R8
        (cs_s_q |=> !so_oe_o && !dual_data_line_oe_o)
        else $error("output still driven after select release");
    ignore_hold_a: assert property // R25
        (state_q == ST_IGNORE && !cs_s_q |=> state_q == ST_IGNORE)
        else $error("left ignore state without select toggle");
    opcode_bits_a: assert property // R23
        ($past(state_q) == ST_OPC && state_q != ST_OPC && !$past(cs_s_q)
         |-> $past(bit_q) == BIT_LAST && $past(rise))
        else $error("opcode taken before eight bits");
    max_dummy_a: assert property // R2
        ($rose(state_q == ST_DATA) && opcode_q == OP_READ_MAX
         |-> $past(state_q) == ST_DUMMY && $past(byte_q) == 2'd1)
        else $error("fast read data without two dummy bytes");
    fast_dummy_a: assert property // R3
        ($rose(state_q == ST_DATA) && opcode_q == OP_READ_FAST
         |-> $past(state_q) == ST_DUMMY && $past(byte_q) == 2'd0)
        else $error("read data without one dummy byte");
    slow_start_a: assert property // R4
        (state_q == ST_ADDR && rise && byte_done && byte_q == 2'd2
         && opcode_q == OP_READ_SLOW |=> state_q == ST_DATA)
        else $error("slow read did not start after address");
    msb_first_a: assert property // R6
        (load && rd_addr_q != '1 |=> so_o == $past(mem_data_i[7])
         && rd_addr_q == $past(rd_addr_q) + ADDR_W'(1))
        else $error("byte not started with its top bit");
    addr_wrap_a: assert property // R7
        (load && rd_addr_q == '1 |=> rd_addr_q == '0)
        else $error("address did not wrap to zero");
    falling_drive_a: assert property // R24
        ($changed(so_o) |-> $past(fall))
        else $error("output changed off a falling edge");
    dual_pair_a: assert property // R27
        (load && info_q.dual |=> dual_data_line_o == $past(mem_data_i[6])
         && dual_data_line_oe_o)
        else $error("dual line missing second bit");

    max_read_c: cover property ($rose(state_q == ST_DATA)
        && opcode_q == OP_READ_MAX);
    wrap_c: cover property (load && rd_addr_q == '1);
    dual_read_c: cover property (load && info_q.dual);
    unknown_op_c: cover property ($rose(state_q == ST_IGNORE)
        && !info_q.known);
endmodule
`default_nettype wire

// File: serial_flash_pkg.sv
// Opcodes, decode record and state codes of the serial flash command path
package serial_flash_pkg;
    localparam int BYTE_W = 8;
    localparam int ADDR_BYTES = 3;
    localparam logic [1:0] NO_BYTES = 2'd0;
    localparam logic [1:0] ONE_BYTE = 2'd1;
    localparam logic [1:0] TWO_BYTES = 2'd2;
    localparam logic [1:0] THREE_BYTES = 2'd3;
    localparam logic [2:0] BIT_FIRST = 3'd0;
    localparam logic [2:0] BIT_LAST = 3'd7;
    localparam logic [2:0] BIT_LAST_DUAL = 3'd6;
    localparam logic [2:0] STEP_SINGLE = 3'd1;
    localparam logic [2:0] STEP_DUAL = 3'd2;

    localparam logic [7:0] OP_READ_MAX = 8'h1b;
    localparam logic [7:0] OP_READ_FAST = 8'h0b;
    localparam logic [7:0] OP_READ_SLOW = 8'h03;
    localparam logic [7:0] OP_READ_DUAL = 8'h3b;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'hc7;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_PROG_DUAL = 8'ha2;
    localparam logic [7:0] OP_SUSPEND = 8'hb0;
    localparam logic [7:0] OP_RESUME = 8'hd0;
    localparam logic [7:0] OP_WR_EN = 8'h06;
    localparam logic [7:0] OP_WR_DIS = 8'h04;
    localparam logic [7:0] OP_PROTECT = 8'h36;
    localparam logic [7:0] OP_UNPROTECT = 8'h39;
    localparam logic [7:0] OP_PROT_RD = 8'h3c;
    localparam logic [7:0] OP_LOCK = 8'h33;
    localparam logic [7:0] OP_LOCK_FREEZE = 8'h34;
    localparam logic [7:0] OP_LOCK_RD = 8'h35;
    localparam logic [7:0] OP_OTP_PROG = 8'h9b;
    localparam logic [7:0] OP_OTP_RD = 8'h77;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR1 = 8'h01;
    localparam logic [7:0] OP_STAT_WR2 = 8'h31;
    localparam logic [7:0] OP_SOFT_RESET = 8'hf0;
    localparam logic [7:0] OP_ID_RD = 8'h9f;
    localparam logic [7:0] OP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_WAKE = 8'hab;

    typedef enum logic [1:0] {
        DIR_NONE = 2'b00,
        DIR_IN = 2'b01,
        DIR_OUT = 2'b10
    } dir_t;

    typedef struct packed {
        logic known;
        logic [1:0] addr_bytes;
        logic [1:0] dummy_bytes;
        dir_t dir;
        logic dual;
        logic one_byte;
    } cmd_info_t;

    typedef enum logic [2:0] {
        ST_OPC = 3'b000,
        ST_ADDR = 3'b001,
        ST_DUMMY = 3'b010,
        ST_DATA = 3'b011,
        ST_IGNORE = 3'b100
    } state_t;
endpackage

// File: spi_host_model.sv
// Behavioural SPI host that drives the serial link of the flash command path
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic so_i,
    input wire logic so_oe_i,
    input wire logic dual_data_line_i,
    input wire logic dual_data_line_oe_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    output logic dual_input_line_o
);
    // 8 MHz link stays well below every per-opcode clock limit
    localparam realtime HALF = 62.5;
    logic si_q = 1'b0;
    logic soi_q = 1'b0;
    logic si_en = 1'b0;
    logic soi_en = 1'b0;
    logic idle_high = 1'b0;
    logic so_cap, sio_cap, oe_cap;

    // A released line shows the inverse of its last value, never a stale bit
    assign dual_input_line_o = so_oe_i ? so_i : (soi_en ? soi_q : ~soi_q);
    assign si_o = dual_data_line_oe_i ? dual_data_line_i
                                      : (si_en ? si_q : ~si_q);

    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
    end

    task automatic start(input logic m3);
        idle_high = m3;
        sck_o = m3;
        #(HALF * 2);
        cs_n_o = 1'b0;
        #HALF;
    endtask

    task automatic stop();
        sck_o = idle_high;
        #HALF;
        cs_n_o = 1'b1;
        si_en = 1'b0;
        soi_en = 1'b0;
        #(HALF * 2);
    endtask

    // Host changes data on the falling edge and samples on the rise
    task automatic clock_bit(input logic [1:0] b, input logic two,
                             input logic rel);
        sck_o = 1'b0;
        si_en = !rel;
        soi_en = two && !rel;
        si_q = two ? b[0] : b[1];
        soi_q = b[1];
        #HALF;
        sck_o = 1'b1;
        so_cap = dual_input_line_o;
        sio_cap = si_o;
        oe_cap = so_oe_i | dual_data_line_oe_i;
        #HALF;
    endtask

    task automatic xfer(input logic [7:0] d, input logic dual,
                        input logic rel, output logic [7:0] q,
                        output logic oe);
        oe = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (!dual) begin
                clock_bit({d[i], d[i]}, 1'b0, rel);
                q[i] = so_cap;
                oe = oe | oe_cap;
            end else if (i % 2 == 1) begin
                // Upper bit of each pair rides on the SO pin
                clock_bit(d[i -: 2], 1'b1, rel);
                q[i] = so_cap;
                q[i - 1] = sio_cap;
                oe = oe | oe_cap;
            end
        end
    endtask
endmodule
`default_nettype wire

// File: serial_flash_cmd_tb.sv
// Self-checking bench for the serial flash decoder and read path
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd_tb
    import serial_flash_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] mem_data_i = 8'h00;
    logic cs_n, sck, si, dual_input_line, so, so_oe, dual_data_line, sio_oe;
    logic rd_byte, cmd_start, wr_valid, cmd_end, cmd_aligned;
    logic last_aligned;
    logic [21:0] mem_addr, cmd_addr;
    logic [7:0] opcode, wr_data;
    int fails = 0;
    int check_count = 0;
    int n_start = 0;
    int n_wr = 0;
    int n_end = 0;
    int n_rd = 0;

    serial_flash_cmd #(.ADDR_W(22)) serial_flash_cmd_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck),
        .si_i(si), .dual_input_line_i(dual_input_line), .so_o(so), .so_oe_o(so_oe),
        .dual_data_line_o(dual_data_line), .dual_data_line_oe_o(sio_oe),
        .mem_addr_o(mem_addr), .mem_data_i(mem_data_i),
        .rd_byte_o(rd_byte), .cmd_start_o(cmd_start), .opcode_o(opcode),
        .cmd_addr_o(cmd_addr), .wr_valid_o(wr_valid), .wr_data_o(wr_data),
        .cmd_end_o(cmd_end), .cmd_aligned_o(cmd_aligned));

    spi_host_model host_i (
        .so_i(so), .so_oe_i(so_oe), .dual_data_line_i(dual_data_line),
        .dual_data_line_oe_i(sio_oe), .cs_n_o(cs_n), .sck_o(sck),
        .si_o(si), .dual_input_line_o(dual_input_line));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [7:0] exp_byte(input logic [21:0] a);
        return a[7:0] ^ {a[21:20], 6'h00};
    endfunction

    // Array stand-in answers one clock after the pointer moves
    always @(posedge clk_i) begin
        mem_data_i <= exp_byte(mem_addr);
        if (cmd_start === 1'b1) n_start <= n_start + 1;
        if (wr_valid === 1'b1) n_wr <= n_wr + 1;
        if (rd_byte === 1'b1) n_rd <= n_rd + 1;
        if (cmd_end === 1'b1) begin
            n_end <= n_end + 1;
            last_aligned <= cmd_aligned;
        end
    end

    task automatic finish_test();
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic header(input logic [7:0] op, input logic [23:0] a,
                          input int na, input int nd, input logic m3,
                          output logic oe);
        logic [7:0] q;
        logic o;
        @(posedge clk_i);
        #1;
        host_i.start(m3);
        host_i.xfer(op, 1'b0, 1'b0, q, oe);
        for (int i = 0; i < na + nd; i++) begin
            host_i.xfer(i < na ? a[23-8*i -: 8] : 8'ha5,
                        1'b0, 1'b0, q, o);
            oe = oe | o;
        end
    endtask

    task automatic t_read(input logic [7:0] op, input int nd,
                          input logic dual, input logic m3,
                          input logic [23:0] a);
        logic [7:0] q;
        logic oe, o;
        int s0, e0, r0;
        s0 = n_start;
        e0 = n_end;
        r0 = n_rd;
        header(op, a, 3, nd, m3, oe);
        check(oe === 1'b0 && n_start == s0 + 1, "read header");
        check(opcode === op && cmd_addr === a[21:0], "read address");
        for (int i = 0; i < 4; i++) begin
            host_i.xfer(8'h00, dual, dual, q, o);
            check(q === exp_byte(a[21:0] + 22'(i)) && o,
                  "read data");
        end
        host_i.stop();
        // Idle-low clock adds one closing fall, which fetches one more byte
        check(so_oe === 1'b0 && sio_oe === 1'b0, "release");
        check(n_end == e0 + 1 && n_rd == r0 + (m3 ? 4 : 5), "bytes");
    endtask

    task automatic t_decode();
        logic [15:0] tbl [25] = '{16'h2080, 16'h5280, 16'hd880, 16'h6000,
            16'hc700, 16'h0284, 16'hb000, 16'hd000, 16'h0600, 16'h0400,
            16'h3680, 16'h3980, 16'h3c88, 16'h3385, 16'h3485, 16'h3588,
            16'h9b84, 16'h77a8, 16'h0508, 16'h0105, 16'h3105, 16'hf005,
            16'h9f08, 16'hb900, 16'hab00};
        logic [7:0] a, q;
        logic oe, o1, o2;
        int s0, w0, e0, nw;
        // Attribute byte: address, dummy count, direction, single byte
        for (int k = 0; k < 25; k++) begin
            a = tbl[k][7:0];
            s0 = n_start;
            w0 = n_wr;
            e0 = n_end;
            header(tbl[k][15:8], 24'h123456, a[7] ? 3 : 0,
                   int'(a[5:4]), 1'b0, oe);
            host_i.xfer(8'h3c, 1'b0, 1'b0, q, o1);
            host_i.xfer(8'hc3, 1'b0, 1'b0, q, o2);
            host_i.stop();
            nw = (a[3:2] == 2'd1) ? (a[0] ? 1 : 2) : 0;
            check(n_start == s0 + 1
                  && opcode === tbl[k][15:8], "decode");
            check(n_wr == w0 + nw && oe === 1'b0,
                  "write count");
            check((o1 | o2) === (a[3:2] == 2'd2),
                  "read phase");
            check(n_end == e0 + 1 && last_aligned === 1'b1, "frame end");
            if (nw != 0) begin
                check(wr_data === (a[0] ? 8'h3c : 8'hc3),
                      "wr byte");
            end
        end
    endtask

    task automatic t_dual_prog();
        logic [7:0] q;
        logic oe, o;
        int w0;
        w0 = n_wr;
        header(OP_PROG_DUAL, 24'hc00100, 3, 0, 1'b0, oe);
        host_i.xfer(8'h96, 1'b1, 1'b0, q, o);
        host_i.stop();
        check(n_wr == w0 + 1 && wr_data === 8'h96, "dual program");
        check(cmd_addr === 22'h000100 && (oe | o) === 1'b0,
              "dual addr");
    endtask

    task automatic t_unknown();
        logic [7:0] q;
        logic oe, o;
        int s0, w0;
        s0 = n_start;
        w0 = n_wr;
        // Valid opcodes after a bad one must stay ignored
        header(8'hff, {OP_WR_EN, OP_PROG, OP_READ_SLOW}, 3, 1, 1'b0, oe);
        host_i.xfer(8'h5a, 1'b0, 1'b0, q, o);
        host_i.stop();
        check(n_start == s0 && n_wr == w0
              && (oe | o) === 1'b0, "unknown");
    endtask

    task automatic t_abort();
        logic oe;
        int s0, e0;
        header(OP_READ_SLOW, 24'h000010, 3, 0, 1'b0, oe);
        for (int i = 0; i < 3; i++) host_i.clock_bit(2'b00, 1'b0, 1'b0);
        host_i.stop();
        check(so_oe === 1'b0 && last_aligned === 1'b0, "abort mid-byte");
        s0 = n_start;
        e0 = n_end;
        @(posedge clk_i);
        #1;
        host_i.start(1'b0);
        for (int i = 7; i > 0; i--) begin
            host_i.clock_bit({2{OP_WR_EN[i]}}, 1'b0, 1'b0);
        end
        host_i.stop();
        check(n_start == s0 && n_end == e0
              && opcode === OP_READ_SLOW, "short op");
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_read(OP_READ_SLOW, 0, 1'b0, 1'b0, 24'hfffffe);
        t_read(OP_READ_FAST, 1, 1'b0, 1'b1, 24'h001234);
        t_read(OP_READ_MAX, 2, 1'b0, 1'b0, 24'h2aaaa9);
        t_read(OP_READ_DUAL, 1, 1'b1, 1'b0, 24'h3ffffd);
        t_decode();
        t_dual_prog();
        t_unknown();
        t_abort();
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        $display("BAD %0t run too long", $time);
        fails++;
        finish_test();
    end
endmodule
`default_nettype wire
